// File: verilog/tsense_pkg.sv
// constants shared by the temperature sensor register block.
// assumes one 25 MHz clock and a byte-level serial front end.
package tsense_pkg;
   // ------------------------------------------------------------
   // register selector codes
   // ------------------------------------------------------------
   localparam logic [7:0] SEL_TEMPERATURE = 8'h00;
   localparam logic [7:0] SEL_CONFIG = 8'h01;
   localparam logic [7:0] SEL_HYST = 8'h02;
   localparam logic [7:0] SEL_OVERTEMP = 8'h03;
   localparam logic [7:0] SEL_ONE_SHOT = 8'h04;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [15:0] TEMPERATURE_RESET = 16'h0000;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [15:0] HYST_RESET = 16'h4b00;
   localparam logic [15:0] OVERTEMP_RESET = 16'h5000;
   localparam logic [7:0] SELECTOR_RESET = 8'h00;
   // ------------------------------------------------------------
   // configuration fields
   // ------------------------------------------------------------
   localparam int CFG_SHUTDOWN = 0;
   localparam int CFG_INT_MODE = 1;
   localparam int CFG_POLARITY = 2;
   localparam int CFG_QUEUE_LO = 3;
   localparam int CFG_QUEUE_HI = 4;
   localparam int CFG_ONE_SHOT = 5;
   localparam int TEMP_FRAC_BITS = 4;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam longint CLK_HZ = 25000000;
   localparam longint CONV_PERIOD_MS = 100;
   localparam longint CONV_TIME_MS = 60;
   // period is a longest time (round down), conversion a least time
   localparam int CONV_PERIOD_CYCLES = int'(CONV_PERIOD_MS * CLK_HZ / 1000);
   localparam int CONV_TIME_CYCLES =
      int'((CONV_TIME_MS * CLK_HZ + 999) / 1000);

   typedef enum logic [1:0] {
      SCHED_IDLE = 2'b00,
      SCHED_CONVERT = 2'b01,
      SCHED_WAIT = 2'b10
   } sched_state_t;

   // consecutive results needed before the alert moves
   function automatic logic [2:0] queue_depth(input logic [1:0] code);
      unique case (code)
         2'b00: queue_depth = 3'd1;
         2'b01: queue_depth = 3'd2;
         2'b10: queue_depth = 3'd4;
         2'b11: queue_depth = 3'd6;
      endcase
   endfunction : queue_depth
endpackage : tsense_pkg

// File: verilog/alert_if.sv
// carries results, limits and alert controls between the register
// block and the alert logic; one clock, no crossing.
interface alert_if;
   logic result_valid;
   logic [15:0] result;
   logic [15:0] hyst;
   logic [15:0] overtemp;
   logic int_mode;
   logic [1:0] queue_code;
   logic read_clear;
   logic one_shot_write;
   logic active;
   modport ctrl(output result_valid, result, hyst, overtemp, int_mode,
      queue_code, read_clear, one_shot_write, input active);
   modport alert(input result_valid, result, hyst, overtemp, int_mode,
      queue_code, read_clear, one_shot_write, output active);
endinterface : alert_if

// File: verilog/conv_sched.sv
// conversion scheduler: periodic or single conversions.
// assumes start and abort are one-cycle pulses on CLK.
module conv_sched #(
   parameter int PERIOD_CYCLES = tsense_pkg::CONV_PERIOD_CYCLES,
   parameter int CONV_CYCLES = tsense_pkg::CONV_TIME_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic abort,
   input wire logic periodic,
   output logic converting,
   output logic done
);
   tsense_pkg::sched_state_t state;
   logic [31:0] count;
   wire count_end = (state == tsense_pkg::SCHED_CONVERT) ?
      (count == 32'(CONV_CYCLES - 1)) :
      (count == 32'(PERIOD_CYCLES - CONV_CYCLES - 1));

   assign converting = (state == tsense_pkg::SCHED_CONVERT);
   assign done = converting && count_end && !abort;

   always_ff @(posedge clk) begin
      count <= (!rst_n || start || abort || count_end) ? 32'h0 : count + 1;
      if (!rst_n || abort) begin
         state <= tsense_pkg::SCHED_IDLE;
      end else if (start) begin
         state <= tsense_pkg::SCHED_CONVERT;
      end else if (count_end) begin
         unique case (state)
            tsense_pkg::SCHED_CONVERT: state <= periodic ?
               tsense_pkg::SCHED_WAIT : tsense_pkg::SCHED_IDLE;
            tsense_pkg::SCHED_WAIT: state <= periodic ?
               tsense_pkg::SCHED_CONVERT : tsense_pkg::SCHED_IDLE;
            default: state <= tsense_pkg::SCHED_IDLE;
         endcase
      end
   end
endmodule : conv_sched

// File: verilog/alert_logic.sv
// over-temperature alert with fault queue, comparator and
// interrupt behaviour; polarity is applied by the caller.
module alert_logic (
   input wire logic clk,
   input wire logic rst_n,
   alert_if.alert bus
);
   logic [2:0] run;
   logic want_cold;
   logic below_hyst;
   wire hot = $signed(bus.result) > $signed(bus.overtemp);
   wire cold = $signed(bus.result) < $signed(bus.hyst);
   wire fault = want_cold ? cold : hot;
   wire [2:0] depth = tsense_pkg::queue_depth(bus.queue_code);
   wire fire = bus.result_valid && fault && (run + 3'd1 >= depth);
   wire cmp_oneshot_clear = !bus.int_mode && bus.one_shot_write
      && below_hyst && bus.active;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         run <= 3'd0;
         want_cold <= 1'b0;
         below_hyst <= 1'b0;
         bus.active <= 1'b0;
      end else begin
         if (bus.result_valid) begin
            below_hyst <= cold;
         end
         // [R12] consecutive fault count
         if (bus.result_valid) begin
            run <= (!fault || fire) ? 3'd0 : run + 3'd1;
         end
         if (fire) begin
            want_cold <= !want_cold;
         end
         // [R22] interrupt set wins over read clear
         if (bus.int_mode) begin
            if (fire && !want_cold) begin
               bus.active <= 1'b1;
            end else if (bus.read_clear) begin
               // [R10] any read releases
               bus.active <= 1'b0;
            end
         end else if (fire) begin
            bus.active <= !want_cold;
         end else if (cmp_oneshot_clear) begin
            // [R11] trigger write releases when cool
            bus.active <= 1'b0;
            want_cold <= 1'b0;
         end
      end
   end
endmodule : alert_logic

// File: verilog/tsense_regs.sv
// register side of a 12-bit digital temperature sensor.
// assumes a byte-level front end on the two-wire bus: a start
// pulse with direction, byte write strobes, byte read requests
// and a stop pulse; the converter result arrives on CONV_CODE.
//
// Overview of operation
// [R1] positive reading is the 12-bit code divided by 16 degrees
// [R2] negative reading is code minus 4096, over 16
// [R3] 9-bit consumer keeps top nine bits, negatives minus 512
// [R4] 8-bit consumer reads whole degrees, negatives minus 256
// [R5] setting the one-shot bit stops periodic conversions at once
// [R6] selector write of one-shot code starts exactly one conversion
// [R7] host waits 60 ms after a trigger before reading
// [R8] reading the one-shot location returns the latest result
// [R9] trigger write drives alert when the result exceeds limits
// [R10] interrupt mode: any read releases the alert
// [R11] comparator mode: trigger write releases alert once cool
// [R12] alert needs the configured count of consecutive faults
// [R13] five registers; configuration 8 bits, the others 16
// [R14] temperature register ignores writes, others are writable
// [R15] selector starts at zero, pointing at the temperature
// [R16] selector low bits route following data bytes
// [R17] selector codes 0 to 4 map to the five locations
// [R18] host writes zeros to unused selector bits
// [R19] temperature is two's complement, high byte read first
// [R20] 12-bit value in bits 15..4, low four bits zero
// [R21] conversions every 100 ms, bus traffic restarts the timer
// [R22] result compared to limits; polarity and mode configured
// [R23] shutdown bit stops conversions, clearing it starts one
// [R24] setpoint writes send high byte then low byte
// [R25] setpoints survive one-shot cycles and shutdown
module tsense_regs #(
   parameter int PERIOD_CYCLES = tsense_pkg::CONV_PERIOD_CYCLES,
   parameter int CONV_CYCLES = tsense_pkg::CONV_TIME_CYCLES
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // serial front end, byte level
   input wire logic BUS_START,
   input wire logic BUS_READ,
   input wire logic BUS_STOP,
   input wire logic BUS_WR_VALID,
   input wire logic [7:0] BUS_WR_DATA,
   input wire logic BUS_RD_REQ,
   output logic [7:0] BUS_RD_DATA,
   // converter
   input wire logic [11:0] CONV_CODE,
   output logic CONVERTING,
   // over-temperature alert, open drain
   output logic ALERT_O,
   output logic ALERT_OE
);
   // ------------------------------------------------------------
   // parameter checks
   // ------------------------------------------------------------
   if (CONV_CYCLES < 1 || PERIOD_CYCLES <= CONV_CYCLES) begin : g_chk
      $error("conversion time must be positive and below the period");
   end

   // ------------------------------------------------------------
   // register state
   // ------------------------------------------------------------
   logic [7:0] selector;
   logic [15:0] temperature_reading;
   logic [7:0] configuration;
   logic [15:0] hysteresis_limit;
   logic [15:0] overtemp_limit;
   logic [7:0] high_stage;
   logic in_txn;
   logic read_txn;
   logic selector_next;
   logic [1:0] byte_idx;
   logic trigger_pending;
   logic conv_done;
   logic alert_drive;

   alert_if aif();

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire wr_selector = BUS_WR_VALID && selector_next;
   wire wr_data = BUS_WR_VALID && in_txn && !selector_next;
   wire shutdown = configuration[tsense_pkg::CFG_SHUTDOWN];
   wire one_shot_mode = configuration[tsense_pkg::CFG_ONE_SHOT];
   // [R5] [R23] one-shot or shutdown halts
   wire periodic = !shutdown && !one_shot_mode;
   // [R17] selector decode
   wire sel_temp = (selector == tsense_pkg::SEL_TEMPERATURE);
   wire sel_cfg = (selector == tsense_pkg::SEL_CONFIG);
   wire sel_hyst = (selector == tsense_pkg::SEL_HYST);
   wire sel_ot = (selector == tsense_pkg::SEL_OVERTEMP);
   wire sel_shot = (selector == tsense_pkg::SEL_ONE_SHOT);
   wire low_byte = byte_idx[0];
   // [R24] setpoints commit on the low byte
   wire commit_hyst = wr_data && sel_hyst && low_byte;
   wire commit_ot = wr_data && sel_ot && low_byte;
   // [R6] trigger only in one-shot mode
   wire trigger_now = wr_selector
      && (BUS_WR_DATA == tsense_pkg::SEL_ONE_SHOT) && one_shot_mode;
   // [R21] stop restarts the timer; one-shot runs only on trigger
   wire sched_start = BUS_STOP && in_txn
      && (periodic || (one_shot_mode && !shutdown && trigger_pending));
   wire [15:0] word_sel = sel_hyst ? hysteresis_limit :
      sel_ot ? overtemp_limit : temperature_reading;
   wire [7:0] rd_byte = sel_cfg ? configuration :
      (sel_temp || sel_hyst || sel_ot || sel_shot) ?
      (low_byte ? word_sel[7:0] : word_sel[15:8]) : 8'h00;

   // ------------------------------------------------------------
   // transaction tracking
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         in_txn <= 1'b0;
         read_txn <= 1'b0;
         selector_next <= 1'b0;
         byte_idx <= 2'd0;
      end else if (BUS_START) begin
         in_txn <= 1'b1;
         read_txn <= BUS_READ;
         selector_next <= !BUS_READ;
         byte_idx <= 2'd0;
      end else begin
         if (BUS_STOP) begin
            in_txn <= 1'b0;
         end
         if (wr_selector) begin
            selector_next <= 1'b0;
         end
         if (wr_data || BUS_RD_REQ) begin
            byte_idx <= {1'b0, !byte_idx[0]};
         end
      end
   end

   // ------------------------------------------------------------
   // selector and configuration
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         // [R15] selector powers up at zero
         selector <= tsense_pkg::SELECTOR_RESET;
         configuration <= tsense_pkg::CONFIG_RESET;
      end else begin
         // [R16] selector routes data bytes
         if (wr_selector) begin
            selector <= BUS_WR_DATA;
         end
         // [R13] eight-bit configuration
         if (wr_data && sel_cfg) begin
            configuration <= BUS_WR_DATA;
         end
      end
   end

   // ------------------------------------------------------------
   // setpoints, kept across shutdown and one-shot
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         hysteresis_limit <= tsense_pkg::HYST_RESET;
         overtemp_limit <= tsense_pkg::OVERTEMP_RESET;
         high_stage <= 8'h00;
      end else begin
         if (wr_data && !low_byte) begin
            high_stage <= BUS_WR_DATA;
         end
         // [R25] only a bus write changes a limit
         if (commit_hyst) begin
            hysteresis_limit <= {high_stage, BUS_WR_DATA};
         end
         if (commit_ot) begin
            overtemp_limit <= {high_stage, BUS_WR_DATA};
         end
      end
   end

   // ------------------------------------------------------------
   // one-shot trigger and result
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         trigger_pending <= 1'b0;
         temperature_reading <= tsense_pkg::TEMPERATURE_RESET;
      end else begin
         if (trigger_now) begin
            trigger_pending <= 1'b1;
         end else if (BUS_STOP) begin
            trigger_pending <= 1'b0;
         end
         // [R1] [R2] code kept two's complement
         // [R20] low four bits always zero
         // [R14] bus writes never reach this register
         if (conv_done) begin
            temperature_reading <=
               {CONV_CODE, {tsense_pkg::TEMP_FRAC_BITS{1'b0}}};
         end
      end
   end

   // [R19] high byte first on reads
   // [R8] one-shot location reads the result
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         BUS_RD_DATA <= 8'h00;
      end else if (BUS_RD_REQ) begin
         BUS_RD_DATA <= rd_byte;
      end
   end

   // ------------------------------------------------------------
   // conversion scheduling
   // ------------------------------------------------------------
   // any start aborts: a read mid-conversion keeps the old result
   conv_sched #(
      .PERIOD_CYCLES(PERIOD_CYCLES),
      .CONV_CYCLES(CONV_CYCLES)
   ) u_sched (
      .clk(CLK),
      .rst_n(RST_N),
      .start(sched_start),
      .abort(BUS_START),
      .periodic(periodic),
      .converting(CONVERTING),
      .done(conv_done)
   );

   // ------------------------------------------------------------
   // alert
   // ------------------------------------------------------------
   // [R9] one-shot result feeds the comparison
   assign aif.result_valid = conv_done;
   assign aif.result = {CONV_CODE, {tsense_pkg::TEMP_FRAC_BITS{1'b0}}};
   assign aif.hyst = hysteresis_limit;
   assign aif.overtemp = overtemp_limit;
   assign aif.int_mode = configuration[tsense_pkg::CFG_INT_MODE];
   assign aif.queue_code =
      configuration[tsense_pkg::CFG_QUEUE_HI:tsense_pkg::CFG_QUEUE_LO];
   assign aif.read_clear = BUS_RD_REQ;
   assign aif.one_shot_write = trigger_now;

   alert_logic u_alert (
      .clk(CLK),
      .rst_n(RST_N),
      .bus(aif)
   );

   // [R22] polarity: pull low when the pin level must be low
   assign alert_drive = configuration[tsense_pkg::CFG_POLARITY] ?
      !aif.active : aif.active;
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ALERT_OE <= 1'b0;
      end else begin
         ALERT_OE <= alert_drive;
      end
   end
   assign ALERT_O = 1'b0;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_trigger_txn;
      trigger_now ##1 (!BUS_START)[*1] ##0 1'b1;
   endsequence
   sequence s_stop_after;
      BUS_STOP && !BUS_START;
   endsequence

   property p_selector_reset;
      @(posedge CLK) !RST_N |=> selector == 8'h00;
   endproperty
   a_selector_reset: assert property (p_selector_reset) // [R15]
      else $error("selector not zero after reset");

   property p_temp_ro;
      @(posedge CLK) disable iff (!RST_N)
         (wr_data && sel_temp && !conv_done) |=> $stable(temperature_reading);
   endproperty
   a_temp_ro: assert property (p_temp_ro) // [R14]
      else $error("bus write changed the temperature reading");

   property p_high_first;
      @(posedge CLK) disable iff (!RST_N)
         (BUS_RD_REQ && sel_temp && !low_byte && !conv_done)
         ##1 (BUS_RD_REQ && !conv_done && !BUS_START)
         |=> BUS_RD_DATA == temperature_reading[7:0]
            && $past(BUS_RD_DATA) == temperature_reading[15:8];
   endproperty
   a_high_first: assert property (p_high_first) // [R19]
      else $error("temperature bytes out of order");

   property p_shot_read;
      @(posedge CLK) disable iff (!RST_N)
         (BUS_RD_REQ && sel_shot && !low_byte)
         |=> BUS_RD_DATA == $past(temperature_reading[15:8]);
   endproperty
   a_shot_read: assert property (p_shot_read) // [R8]
      else $error("one-shot read differs from the result");

   property p_frac_zero;
      @(posedge CLK) disable iff (!RST_N)
         temperature_reading[3:0] == 4'h0;
   endproperty
   a_frac_zero: assert property (p_frac_zero) // [R20]
      else $error("fraction bits of the reading not zero");

   property p_one_shot_starts;
      @(posedge CLK) disable iff (!RST_N)
         first_match(s_trigger_txn ##[0:300] s_stop_after)
            ##0 (!shutdown && one_shot_mode) |=> CONVERTING;
   endproperty
   a_one_shot_starts: assert property (p_one_shot_starts) // [R6]
      else $error("trigger did not start a conversion");

   property p_idle_no_trigger;
      @(posedge CLK) disable iff (!RST_N)
         (BUS_STOP && one_shot_mode && !trigger_pending && !BUS_START)
         |=> !CONVERTING;
   endproperty
   a_idle_no_trigger: assert property (p_idle_no_trigger) // [R5]
      else $error("conversion began in one-shot mode untriggered");

   property p_shutdown_stops;
      @(posedge CLK) disable iff (!RST_N)
         (shutdown && !CONVERTING) |=> !CONVERTING;
   endproperty
   a_shutdown_stops: assert property (p_shutdown_stops) // [R23]
      else $error("conversion began during shutdown");

   property p_restart;
      @(posedge CLK) disable iff (!RST_N)
         (BUS_STOP && in_txn && periodic && !BUS_START) |=> CONVERTING;
   endproperty
   a_restart: assert property (p_restart) // [R21]
      else $error("bus traffic did not restart conversion");

   property p_int_clear;
      @(posedge CLK) disable iff (!RST_N)
         (aif.int_mode && BUS_RD_REQ && !conv_done) |=> !aif.active;
   endproperty
   a_int_clear: assert property (p_int_clear) // [R10]
      else $error("read did not release the interrupt alert");

   property p_setpoint;
      @(posedge CLK) disable iff (!RST_N)
         commit_ot |=> overtemp_limit == {$past(high_stage),
            $past(BUS_WR_DATA)};
   endproperty
   a_setpoint: assert property (p_setpoint) // [R24]
      else $error("setpoint word not assembled high then low");

   property p_alert_pin;
      @(posedge CLK) disable iff (!RST_N)
         1'b1 |=> ALERT_OE == $past(alert_drive);
   endproperty
   a_alert_pin: assert property (p_alert_pin) // [R22]
      else $error("alert pin does not follow state and polarity");
endmodule : tsense_regs

// File: verification/bus_host.sv
// byte-level host model for the sensor's serial front end.
// assumes the block takes each strobe on a rising clk edge.
module bus_host (
   // clock
   input wire logic clk,
   // strobes and data toward the block
   output logic start,
   output logic rd,
   output logic stop,
   output logic wr_valid,
   output logic [7:0] wr_data,
   output logic rd_req,
   // read data from the block
   input wire logic [7:0] rd_data
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      start = 1'b0;
      rd = 1'b0;
      stop = 1'b0;
      wr_valid = 1'b0;
      wr_data = 8'h00;
      rd_req = 1'b0;
   end
   task automatic step();
      @(posedge clk);
      #2;
   endtask : step
   task automatic pulse_start(input logic is_read);
      step();
      start = 1'b1;
      rd = is_read;
      step();
      start = 1'b0;
      rd = ~is_read;
   endtask : pulse_start
   task automatic send_byte(input logic [7:0] b);
      step();
      wr_valid = 1'b1;
      wr_data = b;
      step();
      wr_valid = 1'b0;
      // released data must not look like the last byte
      wr_data = ~b;
   endtask : send_byte
   // zero unused selector bits, high byte first
   task automatic write_reg(input logic [7:0] sel, input logic [15:0] d,
      input int n);
      pulse_start(1'b0);
      send_byte(sel);
      if (n == 2) begin
         send_byte(d[15:8]);
      end
      if (n > 0) begin
         send_byte(d[7:0]);
      end
      step();
      stop = 1'b1;
      step();
      stop = 1'b0;
   endtask : write_reg
   task automatic read_cur(input int n, output logic [15:0] d);
      d = 16'h0000;
      pulse_start(1'b1);
      // back to back requests, each byte taken after its edge
      rd_req = 1'b1;
      repeat (n) begin
         step();
         d = {d[7:0], rd_data};
      end
      rd_req = 1'b0;
      step();
      stop = 1'b1;
      step();
      stop = 1'b0;
   endtask : read_cur
   task automatic read_reg(input logic [7:0] sel, input int n,
      output logic [15:0] d);
      write_reg(sel, 16'h0000, 0);
      read_cur(n, d);
   endtask : read_reg
endmodule : bus_host

// File: verification/tb_top.sv
// self-checking bench for the sensor register block.
// assumes short conversion counts so one-shot runs stay brief.
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int PERIOD = 40;
   localparam int CONV = 10;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] code = 12'h000;
   logic start, rd, stop, wr_valid, rd_req, converting, alert_oe;
   logic alert_o;
   logic [7:0] wr_data, rd_data;
   logic [15:0] got;
   int failures = 0;
   int checks = 0;
   always #20 clk = ~clk;
   tsense_regs #(.PERIOD_CYCLES(PERIOD), .CONV_CYCLES(CONV))
      tsense_regs_inst (.CLK(clk), .RST_N(rst_n), .BUS_START(start),
      .BUS_READ(rd), .BUS_STOP(stop), .BUS_WR_VALID(wr_valid),
      .BUS_WR_DATA(wr_data), .BUS_RD_REQ(rd_req), .BUS_RD_DATA(rd_data),
      .CONV_CODE(code), .CONVERTING(converting), .ALERT_O(alert_o),
      .ALERT_OE(alert_oe));
   bus_host bus_host_inst (.clk(clk), .start(start), .rd(rd),
      .stop(stop), .wr_valid(wr_valid), .wr_data(wr_data),
      .rd_req(rd_req), .rd_data(rd_data));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic wrap_up();
      if (failures == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up
   task automatic check(input string name, input logic [15:0] seen,
      input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic reset_dut();
      @(posedge clk);
      #2;
      rst_n = 1'b0;
      repeat (20) @(posedge clk);
      #2;
      rst_n = 1'b1;
   endtask : reset_dut
   task automatic wait_level(input logic v, input int lim);
      int n;
      n = 0;
      while (converting !== v && n < lim) begin
         @(posedge clk);
         #2;
         n++;
      end
      if (converting !== v) begin
         failures++;
         wrap_up();
      end
   endtask : wait_level
   task automatic idle_for(input int n);
      repeat (n) @(posedge clk);
      #2;
      check("converting", {15'h0000, converting}, 16'h0000);
   endtask : idle_for
   task automatic wr(input logic [7:0] sel, input logic [15:0] d,
      input int n);
      bus_host_inst.write_reg(sel, d, n);
   endtask : wr
   task automatic rd_chk(input logic [7:0] sel, input int n,
      input logic [15:0] exp);
      bus_host_inst.read_reg(sel, n, got);
      check("register", got, exp);
   endtask : rd_chk
   // result taken only once the conversion has ended
   task automatic one_shot(input logic [11:0] c);
      code = c;
      wr(tsense_pkg::SEL_ONE_SHOT, 16'h0000, 0);
      wait_level(1'b1, 8);
      wait_level(1'b0, CONV + 8);
      repeat (2) @(posedge clk);
      #2;
   endtask : one_shot
   task automatic alert_is(input logic v);
      check("alert", {15'h0000, alert_oe}, {15'h0000, v});
      check("alert_data", {15'h0000, alert_o}, 16'h0000);
   endtask : alert_is
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      reset_dut();
      bus_host_inst.read_cur(2, got);
      check("temp", got, tsense_pkg::TEMPERATURE_RESET);
      rd_chk(8'h01, 1, 16'h0000);
      rd_chk(8'h02, 2, tsense_pkg::HYST_RESET);
      rd_chk(8'h03, 2, tsense_pkg::OVERTEMP_RESET);
      wr(8'h00, 16'h1230, 2);
      rd_chk(8'h00, 2, 16'h0000);
      wr(8'h03, 16'h5500, 2);
      rd_chk(8'h03, 2, 16'h5500);
      rd_chk(8'h05, 1, 16'h0000);
      wr(8'h01, 16'h0001, 1);
      idle_for(PERIOD + 4);
      wr(8'h01, 16'h0000, 1);
      wait_level(1'b1, 8);
      wr(8'h01, 16'h0020, 1);
      idle_for(PERIOD + 4);
      one_shot(12'h7d0);
      alert_is(1'b1);
      rd_chk(8'h04, 2, 16'h7d00);
      rd_chk(8'h00, 2, 16'h7d00);
      rd_chk(8'h03, 2, 16'h5500);
      one_shot(12'h190);
      alert_is(1'b0);
      idle_for(PERIOD + 4);
      one_shot(12'hc90);
      rd_chk(8'h00, 2, 16'hc900);
      check("nine_bit", {7'h00, got[15:7]}, 16'h0192);
      rd_chk(8'h00, 1, 16'h00c9);
      wr(8'h01, 16'h0022, 1);
      one_shot(12'h7d0);
      alert_is(1'b1);
      bus_host_inst.read_cur(1, got);
      alert_is(1'b0);
      reset_dut();
      wr(8'h01, 16'h0028, 1);
      one_shot(12'h7d0);
      alert_is(1'b0);
      one_shot(12'h190);
      one_shot(12'h7d0);
      alert_is(1'b0);
      one_shot(12'h7d0);
      alert_is(1'b1);
      // one cool result is below the queue depth, alert stays
      one_shot(12'h190);
      alert_is(1'b1);
      // trigger alone must release, before its conversion ends
      wr(tsense_pkg::SEL_ONE_SHOT, 16'h0000, 0);
      alert_is(1'b0);
      wr(8'h01, 16'h002c, 1);
      alert_is(1'b1);
      wrap_up();
   end
endmodule : tb_top
